// ==== src/tfr_defs.vh ====
/*
  constants of the flight-time result bank: register offsets, widths, reset
  values and timing figures.
  assumes inclusion by bare name from the design files.
*/
`ifndef TFR_DEFS_VH
`define TFR_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TFR_OFS_PLUS_250     7'h78
`define TFR_OFS_PLUS_500     7'h79
`define TFR_OFS_PLUS_750     7'h7A
`define TFR_OFS_PLUS_1000    7'h7B
`define TFR_OFS_FREQ_OFFSET  7'h7C
`define TFR_OFS_TIME_LOW     7'h7D
`define TFR_OFS_TIME_MID     7'h7E
`define TFR_OFS_TIME_HIGH    7'h7F
`define TFR_OFS_WIDTH        7

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TFR_DATA_WIDTH       8
`define TFR_COUNT_WIDTH      24
`define TFR_RESET_BYTE       8'h00
`define TFR_RESET_COUNT      24'h00_0000
`define TFR_LOW_MSB          7
`define TFR_LOW_LSB          0
`define TFR_MID_MSB          15
`define TFR_MID_LSB          8
`define TFR_HIGH_MSB         23
`define TFR_HIGH_LSB         16
`define TFR_TAPS             5

// ----------------------------------------
// timing
// ----------------------------------------
`define TFR_CLK_MHZ          250
`define TFR_SAMPLE_SPACE_NS  250
`define TFR_SAMPLE_CYCLES    ((`TFR_SAMPLE_SPACE_NS * `TFR_CLK_MHZ) / 1000)
`define TFR_COUNT_MHZ        16

`endif

// ==== src/tfr_result_regs.v ====
/*
  read-only result bank of the flight-time measurement mode: correlator
  magnitudes around the main peak, frequency offset estimate, 24-bit count.
  assumes the correlator, offset estimator and 16 MHz counter datapaths sit
  outside on the same clock, and that the serial register port presents an
  address and a read strobe on this clock.
*/
// Overview of operation
// (RULE1) with flight mode enable at 1, correlator samples appear at upper offsets.
// (RULE2) centre sample holds the magnitude exactly at the detected main peak.
// (RULE3) offsets 0x78..0x7B hold magnitudes 250, 500, 750, 1000 ns after peak.
// (RULE4) every sample and count byte is an 8-bit read-only value, zero after reset.
// (RULE5) offset 0x7C holds the frequency offset result in flight mode.
// (RULE6) initial offset estimate is loaded once the PHY header is detected.
// (RULE7) accumulated offset over the frame is loaded at frame end.
// (RULE8) offset is 8-bit two's complement spanning -90 to +90 degrees.
// (RULE9) count bits 7:0 read at offset 0x7D.
// (RULE10) count bits 15:8 read at offset 0x7E.
// (RULE11) count bits 23:16 read at offset 0x7F.
// (RULE12) count comes from a timer stepping at 16 MHz.
// (RULE13) reads have no side effect; values hold until updated or reset.
`timescale 1ns/1ns
`default_nettype none
`include "tfr_defs.vh"

module tfr_result_regs (
  input  wire                         clk_i,
  input  wire                         rst_n_i,
  input  wire                         clk_en_i,
  input  wire                         flight_mode_enable_i,
  input  wire                         corr_mag_valid_i,
  input  wire [`TFR_DATA_WIDTH-1:0]   corr_mag_i,
  input  wire                         corr_peak_i,
  input  wire                         phr_detected_i,
  input  wire                         frame_end_i,
  input  wire [`TFR_DATA_WIDTH-1:0]   freq_offset_initial_i,
  input  wire [`TFR_DATA_WIDTH-1:0]   freq_offset_accum_i,
  input  wire                         flight_count_valid_i,
  input  wire [`TFR_COUNT_WIDTH-1:0]  flight_count_i,
  input  wire                         rd_en_i,
  input  wire [`TFR_OFS_WIDTH-1:0]    rd_addr_i,
  output reg  [`TFR_DATA_WIDTH-1:0]   rd_data_o,
  output reg                          rd_hit_o,
  output wire [`TFR_DATA_WIDTH-1:0]   corr_mag_at_peak_o
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_sync1_reg;
  reg rst_sync2_reg;
  wire rst_n;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  // ----------------------------------------
  // correlator tap capture
  // ----------------------------------------
  // tap 0 is the peak, tap k is k*250 ns later; one sample per 250 ns slot
  reg [`TFR_DATA_WIDTH-1:0] tap_reg [0:`TFR_TAPS-1];
  reg [2:0]                 tap_idx_reg;
  reg                       capturing_reg;
  reg [7:0]                 slot_cnt_reg;
  wire                      slot_due;

  // a slot is due when the sampler says so and the slot counter has reached TFR_SAMPLE_CYCLES - 1
  assign slot_due = corr_mag_valid_i && (slot_cnt_reg >= (`TFR_SAMPLE_CYCLES - 1));

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_idx_reg   <= 3'h0;
      capturing_reg <= 1'b0;
      slot_cnt_reg  <= 8'h00;
    end else if (clk_en_i) begin
      if (flight_mode_enable_i && corr_peak_i && corr_mag_valid_i) begin
        tap_idx_reg   <= 3'h1;
        capturing_reg <= 1'b1;
        slot_cnt_reg  <= 8'h00;
      end else if (capturing_reg) begin
        if (slot_due) begin
          slot_cnt_reg <= 8'h00;
          if (tap_idx_reg == 3'h4) begin
            capturing_reg <= 1'b0;
          end
          tap_idx_reg <= tap_idx_reg + 3'h1;
        end else if (slot_cnt_reg < (`TFR_SAMPLE_CYCLES - 1)) begin
          slot_cnt_reg <= slot_cnt_reg + 8'h01;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TFR_TAPS; g = g + 1) begin : g_tap
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          tap_reg[g] <= `TFR_RESET_BYTE; // see (RULE4)
        end else if (clk_en_i) begin
          if (g == 0) begin
            if (flight_mode_enable_i && corr_peak_i && corr_mag_valid_i) begin
              tap_reg[g] <= corr_mag_i; // see (RULE2)
            end
          end else if (capturing_reg && slot_due && (tap_idx_reg == g)) begin
            tap_reg[g] <= corr_mag_i; // see (RULE3)
          end
        end
      end
    end
  endgenerate

  assign corr_mag_at_peak_o = tap_reg[0];

  // ----------------------------------------
  // frequency offset
  // ----------------------------------------
  // value is passed as signed two's complement, -90..+90 deg, unchanged
  reg [`TFR_DATA_WIDTH-1:0] freq_offset_value_reg;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      freq_offset_value_reg <= `TFR_RESET_BYTE;
    end else if (clk_en_i && flight_mode_enable_i) begin
      // frame end wins: the accumulated figure supersedes the early one
      if (frame_end_i) begin
        freq_offset_value_reg <= freq_offset_accum_i; // see (RULE7) see (RULE8)
      end else if (phr_detected_i) begin
        freq_offset_value_reg <= freq_offset_initial_i; // see (RULE6) see (RULE8)
      end
    end
  end

  // ----------------------------------------
  // flight-time count
  // ----------------------------------------
  // count ticks of the 16 MHz timer; captured whole so the three bytes agree
  reg [`TFR_COUNT_WIDTH-1:0] flight_count_reg;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flight_count_reg <= `TFR_RESET_COUNT;
    end else if (clk_en_i && flight_mode_enable_i && flight_count_valid_i) begin
      flight_count_reg <= flight_count_i; // see (RULE12)
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // reads only select; nothing is cleared or advanced by them
  function [`TFR_DATA_WIDTH:0] tfr_decode;
    input [`TFR_OFS_WIDTH-1:0] addr;
    begin
      case (addr)
        `TFR_OFS_PLUS_250:    tfr_decode = {1'b1, tap_reg[1]}; // see (RULE3)
        `TFR_OFS_PLUS_500:    tfr_decode = {1'b1, tap_reg[2]};
        `TFR_OFS_PLUS_750:    tfr_decode = {1'b1, tap_reg[3]};
        `TFR_OFS_PLUS_1000:   tfr_decode = {1'b1, tap_reg[4]};
        `TFR_OFS_FREQ_OFFSET: tfr_decode = {1'b1, freq_offset_value_reg}; // see (RULE5)
        `TFR_OFS_TIME_LOW:
          tfr_decode = {1'b1, flight_count_reg[`TFR_LOW_MSB:`TFR_LOW_LSB]}; // see (RULE9)
        `TFR_OFS_TIME_MID:
          tfr_decode = {1'b1, flight_count_reg[`TFR_MID_MSB:`TFR_MID_LSB]}; // see (RULE10)
        `TFR_OFS_TIME_HIGH:
          tfr_decode = {1'b1, flight_count_reg[`TFR_HIGH_MSB:`TFR_HIGH_LSB]}; // see (RULE11)
        default:              tfr_decode = {1'b0, `TFR_RESET_BYTE};
      endcase
    end
  endfunction

  wire [`TFR_DATA_WIDTH:0] rd_sel;
  assign rd_sel = tfr_decode(rd_addr_i);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= `TFR_RESET_BYTE;
      rd_hit_o  <= 1'b0;
    end else if (clk_en_i) begin
      if (rd_en_i && flight_mode_enable_i) begin
        rd_hit_o  <= rd_sel[`TFR_DATA_WIDTH]; // see (RULE1)
        rd_data_o <= rd_sel[`TFR_DATA_WIDTH-1:0]; // see (RULE13)
      end else begin
        rd_hit_o  <= 1'b0;
        rd_data_o <= `TFR_RESET_BYTE;
      end
    end
  end

endmodule // tfr_result_regs
`default_nettype wire

// ==== tb/tfr_result_regs_chk.sv ====
/* checker of the flight-time result bank: read answers, peak capture, reset.
   assumes a bind onto tfr_result_regs and a single clock domain. */
`timescale 1ns/1ns
`default_nettype none
module tfr_result_regs_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic        flight_mode_enable_i,
  input wire logic        corr_mag_valid_i,
  input wire logic [7:0]  corr_mag_i,
  input wire logic        corr_peak_i,
  input wire logic        phr_detected_i,
  input wire logic        frame_end_i,
  input wire logic [7:0]  freq_offset_initial_i,
  input wire logic [7:0]  freq_offset_accum_i,
  input wire logic        flight_count_valid_i,
  input wire logic [23:0] flight_count_i,
  input wire logic        rd_en_i,
  input wire logic [6:0]  rd_addr_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        rd_hit_o,
  input wire logic [7:0]  corr_mag_at_peak_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // shadow of the captured values
  // ----------------------------------------
  logic [7:0]  fo_reg;
  logic [23:0] cnt_reg;
  wire logic   live = clk_en_i && flight_mode_enable_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fo_reg  <= 8'h00;
      cnt_reg <= 24'h00_0000;
    end else if (live) begin
      if (frame_end_i) fo_reg <= freq_offset_accum_i;
      else if (phr_detected_i) fo_reg <= freq_offset_initial_i;
      if (flight_count_valid_i) cnt_reg <= flight_count_i;
    end
  end
  sequence s_rd(lo, hi);
    live && rd_en_i && rd_addr_i >= lo && rd_addr_i <= hi;
  endsequence
  property p_fo;
    logic [7:0] v;
    (s_rd(7'h7C, 7'h7C), v = fo_reg) |=> rd_data_o == v;
  endproperty
  property p_cnt;
    logic [7:0] v;
    (s_rd(7'h7D, 7'h7F), v = cnt_reg[8*(rd_addr_i-7'h7D) +: 8]) |=> rd_data_o == v;
  endproperty
  a_map_hit: assert property (s_rd(7'h78, 7'h7F) |=> rd_hit_o) else $error("mapped read missed");
  a_miss_zero: assert property (clk_en_i && rd_en_i && (!flight_mode_enable_i || rd_addr_i < 7'h78)
    |=> !rd_hit_o && rd_data_o == 8'h00) else $error("refused read answered");
  a_idle_zero: assert property (clk_en_i && !rd_en_i |=> !rd_hit_o && rd_data_o == 8'h00)
    else $error("read answer lingered");
  a_peak_load: assert property (live && corr_mag_valid_i && corr_peak_i
    |=> corr_mag_at_peak_o == $past(corr_mag_i)) else $error("peak sample not taken");
  a_peak_hold: assert property (!(live && corr_mag_valid_i && corr_peak_i)
    |=> $stable(corr_mag_at_peak_o)) else $error("peak sample moved");
  a_offset_read: assert property (p_fo) else $error("offset read wrong");
  a_count_bytes: assert property (p_cnt) else $error("count byte wrong");
  a_reset_zero: assert property ($rose(rst_n_i) |-> !rd_hit_o && rd_data_o == 8'h00
    && corr_mag_at_peak_o == 8'h00) else $error("outputs not cleared");
endmodule // tfr_result_regs_chk
`default_nettype wire

// ==== tb/test_tfr_result_regs.sv ====
/* self-checking bench of the flight-time result bank.
   assumes the design and its checker are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module test_tfr_result_regs;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, flight_mode_enable_i = 1'b1;
  logic        corr_mag_valid_i = 1'b0, corr_peak_i = 1'b0, phr_detected_i = 1'b0, frame_end_i = 1'b0;
  logic        flight_count_valid_i = 1'b0, rd_en_i = 1'b0;
  logic [7:0]  corr_mag_i = 8'h00, freq_offset_initial_i = 8'h00, freq_offset_accum_i = 8'h00;
  logic [23:0] flight_count_i = 24'h00_0000;
  logic [6:0]  rd_addr_i = 7'h00;
  wire logic [7:0] rd_data_o, corr_mag_at_peak_o;
  wire logic   rd_hit_o;
  int          err_count = 0, num_checks = 0;
  tfr_result_regs tfr_result_regs_i (.clk_i, .rst_n_i, .clk_en_i, .flight_mode_enable_i, .corr_mag_valid_i,
    .corr_mag_i, .corr_peak_i, .phr_detected_i, .frame_end_i, .freq_offset_initial_i, .freq_offset_accum_i,
    .flight_count_valid_i, .flight_count_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_hit_o, .corr_mag_at_peak_o);
  always #2 clk_i = ~clk_i;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic h, input logic [7:0] d);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 chk(rd_hit_o, h);
    chk(rd_data_o, d);
  endtask
  // strobe bits: peak, valid, header, frame end, count valid
  task automatic ev(input logic [4:0] s, input logic [7:0] m, fi = 8'h00, fa = 8'h00, input logic [23:0] c = 0);
    @(posedge clk_i);
    {corr_peak_i, corr_mag_valid_i, phr_detected_i, frame_end_i, flight_count_valid_i} <= s;
    corr_mag_i <= m;
    freq_offset_initial_i <= fi;
    freq_offset_accum_i <= fa;
    flight_count_i <= c;
    @(posedge clk_i);
    {corr_peak_i, corr_mag_valid_i, phr_detected_i, frame_end_i, flight_count_valid_i} <= 5'h00;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_refuse;
    rd(7'h77, 1'b0, 8'h00);
    @(posedge clk_i);
    flight_mode_enable_i <= 1'b0;
    rd(7'h7C, 1'b0, 8'h00);
    @(posedge clk_i);
    flight_mode_enable_i <= 1'b1;
    $display("test refuse done");
  endtask
  task automatic t_capture;
    logic [7:0] v [5] = '{8'hA5, 8'hFF, 8'h00, 8'h81, 8'h7E};
    ev(5'h18, v[0]);
    // 62 cycles between taking edges is the 250 ns slot
    for (int i = 1; i < 5; i++) begin
      repeat (60) @(posedge clk_i);
      ev(5'h08, v[i]);
    end
    for (int i = 1; i < 5; i++) rd(7'h77 + i[6:0], 1'b1, v[i]);
    chk(corr_mag_at_peak_o, v[0]);
    rd(7'h78, 1'b1, v[1]);
    $display("test capture done");
  endtask
  task automatic t_offset;
    ev(5'h04, 8'h00, 8'hA6);
    rd(7'h7C, 1'b1, 8'hA6);
    ev(5'h06, 8'h00, 8'h11, 8'h5A);
    rd(7'h7C, 1'b1, 8'h5A);
    $display("test offset done");
  endtask
  task automatic t_count;
    ev(5'h01, 8'h00, 8'h00, 8'h00, 24'hAB_CDEF);
    rd(7'h7D, 1'b1, 8'hEF);
    rd(7'h7E, 1'b1, 8'hCD);
    rd(7'h7F, 1'b1, 8'hAB);
    rd(7'h7D, 1'b1, 8'hEF);
    $display("test count done");
  endtask
  // neither a frozen clock nor a disabled mode may let the strobes through
  task automatic t_freeze;
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    ev(5'h1F, 8'h3C, 8'h3C, 8'h3C, 24'h12_3456);
    rd(7'h7C, 1'b0, 8'h00);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    flight_mode_enable_i <= 1'b0;
    ev(5'h1F, 8'h3C, 8'h3C, 8'h3C, 24'h12_3456);
    @(posedge clk_i);
    flight_mode_enable_i <= 1'b1;
    rd(7'h7C, 1'b1, 8'h5A);
    rd(7'h7D, 1'b1, 8'hEF);
    chk(corr_mag_at_peak_o, 8'hA5);
    $display("test freeze done");
  endtask
  task automatic t_reset;
    for (int a = 8'h78; a < 8'h80; a++) rd(a[6:0], 1'b1, 8'h00);
    chk(corr_mag_at_peak_o, 8'h00);
    $display("test reset done");
  endtask
  initial begin
    #100000 err_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_refuse();
    t_capture();
    t_offset();
    t_count();
    t_freeze();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    print_verdict();
  end
endmodule // test_tfr_result_regs
bind tfr_result_regs tfr_result_regs_chk tfr_result_regs_chk_i (.clk_i, .rst_n_i, .clk_en_i, .flight_mode_enable_i,
  .corr_mag_valid_i, .corr_mag_i, .corr_peak_i, .phr_detected_i, .frame_end_i, .freq_offset_initial_i,
  .freq_offset_accum_i, .flight_count_valid_i, .flight_count_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_hit_o,
  .corr_mag_at_peak_o);
`default_nettype wire
